//--- pei_pkg.sv
package pei_pkg;

    // ************************************************************
    // Register addresses on the management bus
    // ************************************************************
    localparam logic [4:0] REG_EVT_ENABLES = 5'h16;
    localparam logic [4:0] REG_EVT_FLAGS   = 5'h17;
    localparam logic [4:0] REG_SLEEP_CTL   = 5'h18;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int NUM_EVENTS   = 11;
    localparam int BIT_EVT_WAKE = 10;
    localparam int BIT_EVT_DPD  = 9;
    localparam int BIT_IRQ_OE   = 15;
    localparam int BIT_RD_CLR   = 14;
    localparam int BIT_POLARITY = 13;
    localparam int BIT_AUTO_CLR = 12;
    localparam int BIT_REARM    = 11;
    localparam int BIT_DPD_EN   = 8;
    localparam int BIT_PLL_SEL  = 7;
    localparam int BIT_RX_SEL   = 6;
    localparam int BIT_DAC_SEL  = 5;
    localparam int BIT_CDR_SEL  = 4;

    // ************************************************************
    // Reset values and writable masks
    // ************************************************************
    localparam logic [15:0] RST_ENABLES    = 16'h0000;
    localparam logic [15:0] RST_SLEEP_CTL  = 16'h0000;
    localparam logic [15:0] MASK_FLAGS     = 16'h07FF;
    localparam logic [15:0] MASK_SLEEP_CTL = 16'h01F0;

    // ************************************************************
    // Management frame constants
    // ************************************************************
    localparam logic [1:0] MGMT_START = 2'h1;
    localparam logic [1:0] MGMT_OP_WR = 2'h1;
    localparam logic [1:0] MGMT_OP_RD = 2'h2;
    localparam int         PRE_BITS   = 32;

    typedef enum logic [2:0] {
        MS_PREAMBLE,
        MS_HEADER,
        MS_TURN,
        MS_DATA
    } pei_mstate_t;

endpackage

//--- pei_sync.sv
`timescale 1ns/10ps
// ************************************************************
// Two flop synchroniser for a group of levels
// ************************************************************
module pei_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             mclk,
    input  wire logic             arst_n,
    // Levels.
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // The first stage is read only by the second.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

//--- pei_mgmt.sv
`timescale 1ns/10ps
// ************************************************************
// Management serial slave: frames bits on the sampled clock
// ************************************************************
module pei_mgmt
    import pei_pkg::*;
(
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // Synchronised pins.
    input  wire logic        mdc_s,
    input  wire logic        mdio_s,
    // Data line drive.
    output logic             mdio_o,
    output logic             mdio_oe,
    // Register access.
    input  wire logic [4:0]  phy_addr,
    output logic             wr_stb,
    output logic             rd_stb,
    output logic [4:0]       reg_addr,
    output logic [15:0]      wr_data,
    input  wire logic [15:0] rd_data
);

    pei_mstate_t state;
    pei_mstate_t next_state;
    logic        mdc_q;
    logic [5:0]  cnt;
    logic [5:0]  next_cnt;
    logic [13:0] hdr;
    logic [13:0] next_hdr;
    logic [15:0] sh;
    logic [15:0] next_sh;
    logic        is_rd;
    logic        next_is_rd;
    logic        mine;
    logic        next_mine;
    logic        next_mdio_o;
    logic        next_mdio_oe;
    logic        next_wr_stb;
    logic        next_rd_stb;
    logic        rise;
    logic        fall;

    assign rise = mdc_s & ~mdc_q;
    assign fall = ~mdc_s & mdc_q;
    assign reg_addr = hdr[4:0];
    assign wr_data  = sh;

    // Next state of the frame decoder; inputs sample on rising clock, the data line drive changes on falling, the strobes on rising.
    always_comb begin
        next_state   = state;
        next_cnt     = cnt;
        next_hdr     = hdr;
        next_sh      = sh;
        next_is_rd   = is_rd;
        next_mine    = mine;
        next_mdio_o  = mdio_o;
        next_mdio_oe = mdio_oe;
        next_wr_stb  = 1'b0;
        next_rd_stb  = 1'b0;
        case (state)
            MS_PREAMBLE: begin
                if (rise) begin
                    if (mdio_s) begin
                        next_cnt = (cnt == 6'(PRE_BITS)) ? cnt : cnt + 6'h01;
                    end else if (cnt == 6'(PRE_BITS)) begin
                        next_state = MS_HEADER;
                        next_cnt   = 6'h00;
                        next_hdr   = '0;
                    end else begin
                        next_cnt = 6'h00;
                    end
                end
            end
            MS_HEADER: begin
                if (rise) begin
                    next_hdr = {hdr[12:0], mdio_s};
                    next_cnt = cnt + 6'h01;
                    if (cnt == 6'h0C) begin
                        // Decode from the header with this last register bit already shifted in.
                        next_is_rd = (next_hdr[11:10] == MGMT_OP_RD);
                        next_mine  = (next_hdr[12] == MGMT_START[0]) && (next_hdr[9:5] == phy_addr);
                        next_state = MS_TURN;
                        next_cnt   = 6'h00;
                    end
                end
            end
            MS_TURN: begin
                if (rise && cnt == 6'h00 && is_rd && mine) begin
                    next_rd_stb = 1'b1;
                end
                if (fall && cnt == 6'h00 && is_rd && mine) begin
                    next_sh = rd_data;
                end
                if (rise) begin
                    next_cnt = cnt + 6'h01;
                    if (cnt == 6'h01) begin
                        next_state = MS_DATA;
                        next_cnt   = 6'h00;
                    end
                end
                // The second turnaround bit is driven low; the top data bit follows it.
                if (fall && cnt == 6'h01 && is_rd && mine) begin
                    next_mdio_oe = 1'b1;
                    next_mdio_o  = 1'b0;
                end
            end
            MS_DATA: begin
                if (is_rd) begin
                    if (fall) begin
                        next_mdio_o = sh[15];
                        next_sh     = {sh[14:0], 1'b0};
                        if (cnt == 6'h10) begin
                            next_mdio_oe = 1'b0;
                            next_state   = MS_PREAMBLE;
                            next_cnt     = 6'h00;
                        end
                    end
                    if (rise) begin
                        next_cnt = cnt + 6'h01;
                    end
                end else if (rise) begin
                    next_sh  = {sh[14:0], mdio_s};
                    next_cnt = cnt + 6'h01;
                    if (cnt == 6'h0F) begin
                        next_wr_stb = mine && (hdr[11:10] == MGMT_OP_WR);
                        next_state  = MS_PREAMBLE;
                        next_cnt    = 6'h00;
                    end
                end
            end
            default: begin
                next_state = MS_PREAMBLE;
            end
        endcase
    end

    // Registers of the frame decoder.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state   <= MS_PREAMBLE;
            mdc_q   <= 1'b0;
            cnt     <= 6'h00;
            hdr     <= '0;
            sh      <= '0;
            is_rd   <= 1'b0;
            mine    <= 1'b0;
            mdio_o  <= 1'b0;
            mdio_oe <= 1'b0;
            wr_stb  <= 1'b0;
            rd_stb  <= 1'b0;
        end else begin
            state   <= next_state;
            mdc_q   <= mdc_s;
            cnt     <= next_cnt;
            hdr     <= next_hdr;
            sh      <= next_sh;
            is_rd   <= next_is_rd;
            mine    <= next_mine;
            mdio_o  <= next_mdio_o;
            mdio_oe <= next_mdio_oe;
            wr_stb  <= next_wr_stb;
            rd_stb  <= next_rd_stb;
        end
    end

endmodule

//--- pei_top.sv
`timescale 1ns/10ps
// Operation
// - Re-arm select 0: writing 1 to a flag clears it, unless the flag sets in the same cycle.
// - Re-arm select 1: written 1 keeps flag set while its condition persists.
// - Enable bit 10 gates the wake-up interrupt.
// - Enable bit 9 gates the deep sleep entry interrupt.
// - Enable bits 8..6 gate negotiation done, jabber, receive error.
// - Enable bits 5..3 gate page received, detect fault, partner acknowledge.
// - Enable bits 2..0 gate link down, remote fault, link up.
// - Flag bit 10 latches on wake-up from deep sleep.
// - Flag bit 9 latches on deep sleep entry.
// - Flag bits 8..6 latch negotiation done, jabber, receive error.
// - Flag bits 5..3 latch page, detect fault, partner acknowledge.
// - Flag bits 2..0 latch link down, remote fault, link up.
// - Flags are cleared by writing 1, zero at reset; bits 15..11 read zero.
// - Deep sleep is entered only with its enable bit set.
// - PLL sleep select powers down the PLL in deep sleep.
// - Receiver sleep select powers down the receiver in deep sleep.
// - Converter sleep select powers down the transmit converter in deep sleep.
// - Clock recovery sleep select powers down clock recovery in deep sleep.
// - Polarity bit selects the active level of the interrupt pin.
// - Read-clear enable makes a flag register read clear set flags.
// - Auto-clear enable clears a flag when its condition goes away.
module pei_top
    import pei_pkg::*;
(
    // Clock and reset.
    input  wire logic                  mclk,
    input  wire logic                  arst_n,
    // Management pins.
    input  wire logic                  mdc,
    input  wire logic                  mdio_i,
    output logic                       mdio_o,
    output logic                       mdio_oe,
    input  wire logic [4:0]            phy_addr,
    // Event conditions, levels from the core.
    input  wire logic [NUM_EVENTS-1:0] evt_cond,
    // Request to sleep from the link monitor, level.
    input  wire logic                  sleep_request,
    // Interrupt pin and power controls.
    output logic                       irq_pin,
    output logic                       deep_sleep_state,
    output logic                       pll_pd,
    output logic                       rx_pd,
    output logic                       dac_pd,
    output logic                       cdr_pd
);

    // ************************************************************
    // Pin synchronisers and bus slave
    // ************************************************************
    logic        mdc_s;
    logic        mdio_s;
    logic        wr_stb;
    logic        rd_stb;
    logic [4:0]  reg_addr;
    logic [15:0] wr_data;
    logic [15:0] rd_data;
    logic        mgmt_o;
    logic        mgmt_oe;

    pei_sync #(.WIDTH(2)) u_sync (
        .mclk     (mclk),
        .arst_n   (arst_n),
        .async_in ({mdc, mdio_i}),
        .sync_out ({mdc_s, mdio_s})
    );

    pei_mgmt u_mgmt (
        .mclk     (mclk),
        .arst_n   (arst_n),
        .mdc_s    (mdc_s),
        .mdio_s   (mdio_s),
        .mdio_o   (mgmt_o),
        .mdio_oe  (mgmt_oe),
        .phy_addr (phy_addr),
        .wr_stb   (wr_stb),
        .rd_stb   (rd_stb),
        .reg_addr (reg_addr),
        .wr_data  (wr_data),
        .rd_data  (rd_data)
    );

    assign mdio_o  = mgmt_o;
    assign mdio_oe = mgmt_oe;

    // ************************************************************
    // Registers and flags
    // ************************************************************
    logic [15:0]           enables;
    logic [15:0]           next_enables;
    logic [15:0]           sleep_ctl;
    logic [15:0]           next_sleep_ctl;
    logic [NUM_EVENTS-1:0] flags;
    logic [NUM_EVENTS-1:0] next_flags;
    logic [NUM_EVENTS-1:0] cond_q;
    logic [NUM_EVENTS-1:0] cond_rise;
    logic [NUM_EVENTS-1:0] wr1_clr;
    logic [NUM_EVENTS-1:0] rd_clr;
    logic                  sleep_now;
    logic                  sleep_q;
    logic [NUM_EVENTS-1:0] src;
    logic                  next_irq;

    // Sleep entry and wake are events generated here, not by the core.
    assign sleep_now = sleep_request & sleep_ctl[BIT_DPD_EN];
    assign src = {sleep_q & ~sleep_now, sleep_now & ~sleep_q, evt_cond[8:0]};

    function automatic logic hit(input logic [4:0] a, input logic [4:0] b);
        hit = (a == b);
    endfunction

    assign rd_data = hit(reg_addr, REG_EVT_ENABLES) ? enables :
                     hit(reg_addr, REG_EVT_FLAGS)   ? (16'(flags) & MASK_FLAGS) :
                     hit(reg_addr, REG_SLEEP_CTL)   ? sleep_ctl : 16'h0000;

    // A flag sets on each rising edge of its condition; set beats every clear.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_flag
            assign cond_rise[gi] = src[gi] & ~cond_q[gi];
            // Written 1 clears, unless re-arm keeps it while the condition holds.
            assign wr1_clr[gi] = wr_stb && hit(reg_addr, REG_EVT_FLAGS) && wr_data[gi] &&
                                 !(enables[BIT_REARM] && src[gi]);
            assign rd_clr[gi]  = rd_stb && hit(reg_addr, REG_EVT_FLAGS) && enables[BIT_RD_CLR];
            always_comb begin
                next_flags[gi] = flags[gi];
                if (wr1_clr[gi] || rd_clr[gi] ||
                    (enables[BIT_AUTO_CLR] && !src[gi])) begin
                    next_flags[gi] = 1'b0;
                end
                if (cond_rise[gi]) begin
                    next_flags[gi] = 1'b1;
                end
            end
        end
    endgenerate

    // Control register writes; reserved sleep bits are held at zero.
    always_comb begin
        next_enables   = enables;
        next_sleep_ctl = sleep_ctl;
        if (wr_stb && hit(reg_addr, REG_EVT_ENABLES)) begin
            next_enables = wr_data;
        end
        if (wr_stb && hit(reg_addr, REG_SLEEP_CTL)) begin
            next_sleep_ctl = wr_data & MASK_SLEEP_CTL;
        end
    end

    // Enabled flags drive the pin at the selected polarity.
    always_comb begin
        next_irq = enables[BIT_IRQ_OE] && |(flags & enables[NUM_EVENTS-1:0]);
        next_irq = next_irq ~^ enables[BIT_POLARITY];
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            enables          <= RST_ENABLES;
            sleep_ctl        <= RST_SLEEP_CTL;
            flags            <= '0;
            cond_q           <= '0;
            sleep_q          <= 1'b0;
            irq_pin          <= 1'b1;
            deep_sleep_state <= 1'b0;
            pll_pd           <= 1'b0;
            rx_pd            <= 1'b0;
            dac_pd           <= 1'b0;
            cdr_pd           <= 1'b0;
        end else begin
            enables          <= next_enables;
            sleep_ctl        <= next_sleep_ctl;
            flags            <= next_flags;
            cond_q           <= src;
            sleep_q          <= sleep_now;
            irq_pin          <= next_irq;
            deep_sleep_state <= sleep_now;
            pll_pd           <= sleep_now & sleep_ctl[BIT_PLL_SEL];
            rx_pd            <= sleep_now & sleep_ctl[BIT_RX_SEL];
            dac_pd           <= sleep_now & sleep_ctl[BIT_DAC_SEL];
            cdr_pd           <= sleep_now & sleep_ctl[BIT_CDR_SEL];
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    property p_no_sleep;
        @(posedge mclk) disable iff (!arst_n) !sleep_ctl[BIT_DPD_EN] |=> !deep_sleep_state;
    endproperty
    a_no_sleep: assert property (p_no_sleep) else $error("deep sleep without enable");

    property p_pll;
        @(posedge mclk) disable iff (!arst_n) pll_pd |-> deep_sleep_state;
    endproperty
    a_pll: assert property (p_pll) else $error("pll down outside deep sleep");

    property p_set;
        @(posedge mclk) disable iff (!arst_n) |cond_rise |=> |flags;
    endproperty
    a_set: assert property (p_set) else $error("event not latched");

    property p_irq_off;
        @(posedge mclk) disable iff (!arst_n) !enables[BIT_IRQ_OE] |=> irq_pin == !$past(enables[BIT_POLARITY]);
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq active while disabled");

    property p_rdclr;
        @(posedge mclk) disable iff (!arst_n) (|rd_clr && !(|cond_rise)) |=> flags == '0;
    endproperty
    a_rdclr: assert property (p_rdclr) else $error("read did not clear flags");

    property p_wr1;
        @(posedge mclk) disable iff (!arst_n) (wr1_clr[0] && !cond_rise[0]) |=> !flags[0];
    endproperty
    a_wr1: assert property (p_wr1) else $error("write one did not clear");

    property p_rearm;
        @(posedge mclk) disable iff (!arst_n)
            (wr_stb && hit(reg_addr, REG_EVT_FLAGS) && enables[BIT_REARM] && flags[0] && src[0] && !rd_clr[0]
             && !enables[BIT_AUTO_CLR]) |=> flags[0];
    endproperty
    a_rearm: assert property (p_rearm) else $error("re-arm lost flag");

    property p_auto;
        @(posedge mclk) disable iff (!arst_n) enables[BIT_AUTO_CLR] |=> (flags & ~$past(src)) == '0;
    endproperty
    a_auto: assert property (p_auto) else $error("auto clear failed");

endmodule

//--- pei_sta.sv
`timescale 1ns/10ps
// ************************************************************
// Station management model: frames register accesses
// ************************************************************
module pei_sta
    import pei_pkg::*;
(
    // Pacing clock.
    input  wire logic mclk,
    // Management pins.
    output logic      mdc,
    output logic      sta_o,
    output logic      sta_oe,
    input  wire logic mdio_line
);
    // Between frames the clock stands low and the line is left to its pull-up.
    initial begin
        mdc = 1'b0;
        sta_o = 1'b1;
        sta_oe = 1'b0;
    end

    // One bit slot: data changes while the clock is low, the line is captured at the end of the high phase.
    task automatic slot(input logic drv, input logic val, output logic seen);
        sta_oe = drv;
        sta_o = val;
        repeat (10) @(negedge mclk);
        mdc = 1'b1;
        repeat (10) @(negedge mclk);
        seen = mdio_line;
        mdc = 1'b0;
    endtask

    // Whole frame; a read releases the line from the turnaround onwards.
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rdv);
        logic [13:0] hdr;
        logic        s;
        logic        wrop;
        hdr = {MGMT_START, op, pa, ra};
        wrop = (op == MGMT_OP_WR);
        for (int i = 0; i < PRE_BITS; i++) begin
            slot(1'b1, 1'b1, s);
        end
        for (int i = 13; i >= 0; i--) begin
            slot(1'b1, hdr[i], s);
        end
        slot(wrop, 1'b1, s);
        slot(wrop, 1'b0, s);
        for (int i = 15; i >= 0; i--) begin
            slot(wrop, wd[i], s);
            rdv[i] = s;
        end
        // A trailing slot with the line released follows; the device lets go at the falling edge that ends the last data slot.
        slot(1'b0, 1'b1, s);
    endtask
endmodule

//--- testbench.sv
`timescale 1ns/10ps
// ************************************************************
// Self-checking bench for the event interrupt and sleep block
// ************************************************************
module testbench
    import pei_pkg::*;
;
    localparam logic [4:0] PHY_A = 5'h05;
    logic                  mclk = 1'b0;
    logic                  arst_n = 1'b0;
    logic [10:0]           evt_cond = 11'h000;
    logic                  sleep_request = 1'b0;
    wire                   mdc, sta_o, sta_oe, mdio_o, mdio_oe;
    wire                   irq_pin, deep_sleep_state, pll_pd, rx_pd, dac_pd, cdr_pd;
    wire                   mdio_line;
    logic [15:0]           m_en = 16'h0000, m_sc = 16'h0000, m_fl = 16'h0000, m_cond = 16'h0000;
    logic                  m_req = 1'b0;
    logic [31:0]           rnd;
    logic [15:0]           en_r;
    int                    n_mismatch = 0;
    int                    compares = 0;

    // Free running core clock.
    always #4 mclk = ~mclk;

    // Shared line: device, then controller, else the pull-up.
    assign mdio_line = mdio_oe ? mdio_o : (sta_oe ? sta_o : 1'b1);

    pei_top uut (.mclk(mclk), .arst_n(arst_n), .mdc(mdc), .mdio_i(mdio_line), .mdio_o(mdio_o),
        .mdio_oe(mdio_oe), .phy_addr(PHY_A), .evt_cond(evt_cond), .sleep_request(sleep_request),
        .irq_pin(irq_pin), .deep_sleep_state(deep_sleep_state), .pll_pd(pll_pd), .rx_pd(rx_pd),
        .dac_pd(dac_pd), .cdr_pd(cdr_pd));
    pei_sta sta (.mclk(mclk), .mdc(mdc), .sta_o(sta_o), .sta_oe(sta_oe), .mdio_line(mdio_line));

    task automatic complete_run();
        if (n_mismatch == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Pins against the model; auto-clear is applied first since it acts continuously.
    task automatic check_pins();
        logic act;
        logic ds;
        if (m_en[BIT_AUTO_CLR]) m_fl &= (m_cond | 16'h0600);
        act = m_en[BIT_IRQ_OE] && ((m_fl & m_en & MASK_FLAGS) != 16'h0000);
        ds = m_req && m_sc[BIT_DPD_EN];
        chk("irq_pin", 16'(m_en[BIT_POLARITY] ? act : !act), 16'(irq_pin));
        chk("deep_sleep_state", 16'(ds), 16'(deep_sleep_state));
        chk("power_down", 16'({4{ds}} & m_sc[7:4]), 16'({pll_pd, rx_pd, dac_pd, cdr_pd}));
    endtask

    // Changes conditions at a falling edge; the model latches rises and sleep entry and exit.
    task automatic step(input logic [15:0] cond, input logic req);
        logic was;
        logic now;
        was = m_req && m_sc[BIT_DPD_EN];
        now = req && m_sc[BIT_DPD_EN];
        m_fl |= cond & ~m_cond & 16'h01FF;
        if (now && !was) m_fl[BIT_EVT_DPD] = 1'b1;
        if (was && !now) m_fl[BIT_EVT_WAKE] = 1'b1;
        m_cond = cond & 16'h01FF;
        m_req = req;
        @(negedge mclk);
        evt_cond = cond[10:0];
        sleep_request = req;
        repeat (6) @(negedge mclk);
        check_pins();
    endtask

    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] junk;
        sta.frame(MGMT_OP_WR, PHY_A, ra, d, junk);
        if (ra == REG_EVT_ENABLES) m_en = d;
        if (ra == REG_SLEEP_CTL) m_sc = d & MASK_SLEEP_CTL;
        if (ra == REG_EVT_FLAGS) m_fl &= ~(d & (m_en[BIT_REARM] ? ~m_cond : 16'hFFFF));
        check_pins();
    endtask

    task automatic rd(input logic [4:0] ra, input logic [4:0] pa);
        logic [15:0] exp;
        logic [15:0] got;
        exp = 16'h0000;
        if (ra == REG_EVT_ENABLES) exp = m_en;
        if (ra == REG_EVT_FLAGS) exp = m_fl;
        if (ra == REG_SLEEP_CTL) exp = m_sc;
        if (pa != PHY_A) exp = 16'hFFFF;
        sta.frame(MGMT_OP_RD, pa, ra, 16'h0000, got);
        chk("read_data", exp, got);
        if (ra == REG_EVT_FLAGS && pa == PHY_A && m_en[BIT_RD_CLR]) m_fl = 16'h0000;
        check_pins();
    endtask

    // Hang guard: a run about 11000 cycles beyond its length counts as a mismatch.
    initial begin
        repeat (95000) @(negedge mclk);
        n_mismatch++;
        complete_run();
    end

    // Main sequence.
    initial begin
        rnd = $urandom(32'h94fdeb2f);
        repeat (5) @(negedge mclk);
        arst_n = 1'b1;
        check_pins();
        rd(REG_EVT_ENABLES, PHY_A);
        rd(REG_EVT_FLAGS, PHY_A);
        rd(REG_SLEEP_CTL, PHY_A);
        wr(5'h10, 16'hA5A5);
        rd(5'h10, PHY_A);
        rd(REG_EVT_ENABLES, PHY_A + 5'h01);
        // Each of the nine core events with random enables, then with the complement and the other polarity.
        rnd = $urandom;
        en_r = rnd[15:0];
        for (int p = 0; p < 2; p++) begin
            wr(REG_EVT_ENABLES, 16'h8000 | (p ? 16'h2000 : 16'h0000) | ((p ? ~en_r : en_r) & MASK_FLAGS));
            rd(REG_EVT_ENABLES, PHY_A);
            for (int i = 0; i < 9; i++) begin
                rnd = $urandom;
                step((16'h0001 << i) | (rnd[15:0] & 16'h0600), 1'b0);
                rd(REG_EVT_FLAGS, PHY_A);
                wr(REG_EVT_FLAGS, 16'h0001 << i);
                step(16'h0000, 1'b0);
            end
        end
        // Re-arm: a flag whose condition persists survives the write, reads do not clear.
        wr(REG_EVT_ENABLES, 16'h8805);
        step(16'h0005, 1'b0);
        step(16'h0001, 1'b0);
        wr(REG_EVT_FLAGS, 16'h0005);
        rd(REG_EVT_FLAGS, PHY_A);
        rd(REG_EVT_FLAGS, PHY_A);
        step(16'h0000, 1'b0);
        wr(REG_EVT_FLAGS, 16'h0001);
        // Read clear.
        wr(REG_EVT_ENABLES, 16'hC018);
        step(16'h0018, 1'b0);
        rd(REG_EVT_FLAGS, PHY_A);
        rd(REG_EVT_FLAGS, PHY_A);
        step(16'h0000, 1'b0);
        // Auto-clear on removal of the condition.
        wr(REG_EVT_ENABLES, 16'h9060);
        step(16'h0060, 1'b0);
        step(16'h0020, 1'b0);
        rd(REG_EVT_FLAGS, PHY_A);
        step(16'h0000, 1'b0);
        // Deep sleep refused while disabled, then entered and left with random selects.
        wr(REG_EVT_ENABLES, 16'h8600);
        rnd = $urandom;
        wr(REG_SLEEP_CTL, rnd[15:0] & 16'h00F0);
        step(16'h0000, 1'b1);
        step(16'h0000, 1'b0);
        wr(REG_SLEEP_CTL, (rnd[15:0] & 16'h00F0) | 16'h0100);
        rd(REG_SLEEP_CTL, PHY_A);
        step(16'h0000, 1'b1);
        rd(REG_EVT_FLAGS, PHY_A);
        step(16'h0000, 1'b0);
        rd(REG_EVT_FLAGS, PHY_A);
        wr(REG_EVT_FLAGS, 16'h0600);
        rd(REG_EVT_FLAGS, PHY_A);
        complete_run();
    end
endmodule
